// ==== cpw_top.sv ====
// Summary of operation
// RULE1: compare match turns negative phase on
// RULE2: temporary match turns negative phase off
// RULE3: temporary match while off keeps it off
// RULE4: compare match turns positive phase off
// RULE5: temporary match turns positive phase on
// RULE6: off holds; later on match ignored
// RULE7: negative phase starts at selected level
// RULE8: same outputs for either overwrite interval
// RULE9: mode 3 differs only in transfer point
// RULE10: negative pulses narrow freely, no suppression
// RULE11: positive pulses narrow freely near zero
// RULE12: positive pulses narrow near half period
// RULE13: negative pulses narrow near period compare
// RULE14: simultaneous positive matches change nothing
// RULE15: software avoids regions giving minute pulses
// RULE16: buffer, temporary, compare move at transfer points; buffer to temporary moves on the write, or at band end
package cpw_pkg;
   localparam int W = 16;
   // register word offsets
   localparam logic [3:0] OFS_CTRL      = 4'h0;
   localparam logic [3:0] OFS_DEAD      = 4'h1;
   localparam logic [3:0] OFS_HALF      = 4'h2;
   localparam logic [3:0] OFS_PERIOD    = 4'h3;
   localparam logic [3:0] OFS_DUTY_A    = 4'h4;
   localparam logic [3:0] OFS_DUTY_B    = 4'h5;
   localparam logic [3:0] OFS_STATUS    = 4'h6;
   localparam logic [3:0] OFS_COUNT     = 4'h7;
   localparam logic [3:0] OFS_TEMP_A    = 4'h8;
   localparam logic [3:0] OFS_COMPARE_A = 4'h9;
   localparam logic [3:0] OFS_TEMP_B    = 4'hA;
   localparam logic [3:0] OFS_COMPARE_B = 4'hB;
   // control bit positions
   localparam int CTRL_RUN    = 0;
   localparam int CTRL_MODE3  = 1;
   localparam int CTRL_NEG_LVL_A = 2;
   localparam int CTRL_NEG_LVL_B = 3;
   // status bit positions
   localparam int ST_POS_A = 0;
   localparam int ST_NEG_A = 1;
   localparam int ST_POS_B = 2;
   localparam int ST_NEG_B = 3;
   localparam int ST_DOWN  = 4;
   localparam int ST_BAND  = 5;
   localparam int ST_RUN   = 6;
   // reset values
   localparam logic [W-1:0] RST_CTRL = 16'h0000;
   localparam logic [W-1:0] RST_DEAD = 16'h0010;
   localparam logic [W-1:0] RST_HALF = 16'h0100;
   localparam logic [W-1:0] RST_DUTY = 16'h0088;
   localparam logic [W-1:0] ZERO     = 16'h0000;
   localparam logic [W-1:0] ONE      = 16'h0001;
   // counter sequencing
   typedef enum logic [2:0] {
      CNT_IDLE = 3'b001,
      CNT_UP   = 3'b010,
      CNT_DOWN = 3'b100
   } cpw_cnt_e;
endpackage

`timescale 1ns/10ps
module cpw_top (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic [3:0]           reg_addr,
   input  wire logic [cpw_pkg::W-1:0] reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [cpw_pkg::W-1:0] reg_rdata,
   output logic                      pos_phase_a,
   output logic                      neg_phase_a,
   output logic                      pos_phase_b,
   output logic                      neg_phase_b
);
   logic [cpw_pkg::W-1:0] ctrl;
   logic [cpw_pkg::W-1:0] dead_time_value;
   logic [cpw_pkg::W-1:0] carrier_half_period_value;
   logic [cpw_pkg::W-1:0] next_ctrl;
   logic [cpw_pkg::W-1:0] next_dead;
   logic [cpw_pkg::W-1:0] next_half;
   logic [cpw_pkg::W-1:0] next_rdata;
   logic [cpw_pkg::W-1:0] period_compare_reg;
   logic [cpw_pkg::W-1:0] cnt;
   logic [cpw_pkg::W-1:0] next_cnt;
   cpw_pkg::cpw_cnt_e     state;
   cpw_pkg::cpw_cnt_e     next_state;
   logic                  run_q;
   logic                  next_run_q;
   logic                  start;
   logic                  running;
   logic                  crest;
   logic                  trough;
   logic                  xfer;
   logic                  interval_near_peak;
   logic                  wr_ctrl;
   logic                  wr_duty_a;
   logic                  wr_duty_b;
   logic [cpw_pkg::W-1:0] temp_a;
   logic [cpw_pkg::W-1:0] temp_b;
   logic [cpw_pkg::W-1:0] cmp_a;
   logic [cpw_pkg::W-1:0] cmp_b;
   logic [cpw_pkg::W-1:0] status;

   // peak of the triangle: half period plus dead time
   assign period_compare_reg = carrier_half_period_value + dead_time_value;

   // write decode
   assign wr_ctrl   = reg_wr && (reg_addr == cpw_pkg::OFS_CTRL);
   assign wr_duty_a = reg_wr && (reg_addr == cpw_pkg::OFS_DUTY_A);
   assign wr_duty_b = reg_wr && (reg_addr == cpw_pkg::OFS_DUTY_B);

   // configuration registers; half period and dead time only take while stopped,
   // so the triangle never sees a peak that moves under it
   always_comb begin
      next_ctrl = ctrl;
      next_dead = dead_time_value;
      next_half = carrier_half_period_value;
      if (wr_ctrl) begin
         next_ctrl = reg_wdata & 16'h000F;
      end
      if (reg_wr && !running && reg_addr == cpw_pkg::OFS_DEAD) begin
         next_dead = reg_wdata;
      end
      if (reg_wr && !running && reg_addr == cpw_pkg::OFS_HALF) begin
         next_half = reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl                      <= cpw_pkg::RST_CTRL;
         dead_time_value           <= cpw_pkg::RST_DEAD;
         carrier_half_period_value <= cpw_pkg::RST_HALF;
      end else begin
         ctrl                      <= next_ctrl;
         dead_time_value           <= next_dead;
         carrier_half_period_value <= next_half;
      end
   end

   // run edge gives the output start pulse
   assign next_run_q = ctrl[cpw_pkg::CTRL_RUN];
   assign start      = ctrl[cpw_pkg::CTRL_RUN] && !run_q;
   assign running    = (state != cpw_pkg::CNT_IDLE);

   // triangle counter, up from zero to the peak and back
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         cpw_pkg::CNT_IDLE: begin
            next_cnt = cpw_pkg::ZERO;
            if (start) begin
               next_state = cpw_pkg::CNT_UP;
            end
         end
         cpw_pkg::CNT_UP: begin
            if (!ctrl[cpw_pkg::CTRL_RUN]) begin
               next_state = cpw_pkg::CNT_IDLE;
            end else if (cnt >= period_compare_reg) begin
               next_state = cpw_pkg::CNT_DOWN;
               next_cnt   = cnt - cpw_pkg::ONE;
            end else begin
               next_cnt = cnt + cpw_pkg::ONE;
            end
         end
         cpw_pkg::CNT_DOWN: begin
            if (!ctrl[cpw_pkg::CTRL_RUN]) begin
               next_state = cpw_pkg::CNT_IDLE;
            end else if (cnt == cpw_pkg::ZERO) begin
               next_state = cpw_pkg::CNT_UP;
               next_cnt   = cpw_pkg::ONE;
            end else begin
               next_cnt = cnt - cpw_pkg::ONE;
            end
         end
         default: begin
            next_state = cpw_pkg::CNT_IDLE;
            next_cnt   = cpw_pkg::ZERO;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= cpw_pkg::CNT_IDLE;
         cnt   <= cpw_pkg::ZERO;
         run_q <= 1'b0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         run_q <= next_run_q;
      end
   end

   // crest and trough events and the dead-time band around them
   assign crest  = (state == cpw_pkg::CNT_UP) && (cnt >= period_compare_reg);
   assign trough = (state == cpw_pkg::CNT_DOWN) && (cnt == cpw_pkg::ZERO);
   assign interval_near_peak = running &&
                               ((cnt + dead_time_value > period_compare_reg) ||
                                (cnt < dead_time_value));
   // mode 2 moves temporary to compare at the crest, mode 3 at the trough
   assign xfer = ctrl[cpw_pkg::CTRL_MODE3] ? trough : crest; // see RULE9

   // one channel group per output pair
   cpw_chan u_chan_a (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .start    (start),
      .running  (running),
      .neg_lvl  (ctrl[cpw_pkg::CTRL_NEG_LVL_A]),
      .cnt      (cnt),
      .buf_wr   (wr_duty_a),
      .buf_data (reg_wdata),
      .in_band  (interval_near_peak),
      .xfer     (xfer),
      .pos      (pos_phase_a),
      .neg      (neg_phase_a),
      .temp_val (temp_a),
      .cmp_val  (cmp_a),
      .buf_val  ()
   );

   cpw_chan u_chan_b (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .start    (start),
      .running  (running),
      .neg_lvl  (ctrl[cpw_pkg::CTRL_NEG_LVL_B]),
      .cnt      (cnt),
      .buf_wr   (wr_duty_b),
      .buf_data (reg_wdata),
      .in_band  (interval_near_peak),
      .xfer     (xfer),
      .pos      (pos_phase_b),
      .neg      (neg_phase_b),
      .temp_val (temp_b),
      .cmp_val  (cmp_b),
      .buf_val  ()
   );

   // live state gathered for software
   always_comb begin
      status                      = cpw_pkg::ZERO;
      status[cpw_pkg::ST_POS_A]   = pos_phase_a;
      status[cpw_pkg::ST_NEG_A]   = neg_phase_a;
      status[cpw_pkg::ST_POS_B]   = pos_phase_b;
      status[cpw_pkg::ST_NEG_B]   = neg_phase_b;
      status[cpw_pkg::ST_DOWN]    = (state == cpw_pkg::CNT_DOWN);
      status[cpw_pkg::ST_BAND]    = interval_near_peak;
      status[cpw_pkg::ST_RUN]     = running;
   end

   // read mux; data valid only in the cycle after the strobe, zero otherwise
   logic [cpw_pkg::W-1:0] buf_a_rd;
   logic [cpw_pkg::W-1:0] buf_b_rd;
   assign buf_a_rd = temp_a;
   assign buf_b_rd = temp_b;
   always_comb begin
      next_rdata = cpw_pkg::ZERO;
      if (reg_rd) begin
         case (reg_addr)
            cpw_pkg::OFS_CTRL:      next_rdata = ctrl;
            cpw_pkg::OFS_DEAD:      next_rdata = dead_time_value;
            cpw_pkg::OFS_HALF:      next_rdata = carrier_half_period_value;
            cpw_pkg::OFS_PERIOD:    next_rdata = period_compare_reg;
            cpw_pkg::OFS_STATUS:    next_rdata = status;
            cpw_pkg::OFS_COUNT:     next_rdata = cnt;
            cpw_pkg::OFS_TEMP_A:    next_rdata = buf_a_rd;
            cpw_pkg::OFS_COMPARE_A: next_rdata = cmp_a;
            cpw_pkg::OFS_TEMP_B:    next_rdata = buf_b_rd;
            cpw_pkg::OFS_COMPARE_B: next_rdata = cmp_b;
            default:                next_rdata = cpw_pkg::ZERO;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= cpw_pkg::ZERO;
      end else begin
         reg_rdata <= next_rdata;
      end
   end
endmodule

// ==== cpw_chan.sv ====
`timescale 1ns/10ps
module cpw_chan (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  start,
   input  wire logic                  running,
   input  wire logic                  neg_lvl,
   input  wire logic [cpw_pkg::W-1:0] cnt,
   input  wire logic                  buf_wr,
   input  wire logic [cpw_pkg::W-1:0] buf_data,
   input  wire logic                  in_band,
   input  wire logic                  xfer,
   output logic                       pos,
   output logic                       neg,
   output logic      [cpw_pkg::W-1:0] temp_val,
   output logic      [cpw_pkg::W-1:0] cmp_val,
   output logic      [cpw_pkg::W-1:0] buf_val
);
   logic [cpw_pkg::W-1:0] duty_buffer_reg;
   logic [cpw_pkg::W-1:0] duty_temp_reg;
   logic [cpw_pkg::W-1:0] duty_compare_reg;
   logic [cpw_pkg::W-1:0] next_buf;
   logic [cpw_pkg::W-1:0] next_temp;
   logic [cpw_pkg::W-1:0] next_cmp;
   logic                  pending;
   logic                  next_pending;
   logic                  off_hold;
   logic                  next_off_hold;
   logic                  next_pos;
   logic                  next_neg;
   logic                  cmp_match;
   logic                  tmp_match;

   assign cmp_match = running && (cnt == duty_compare_reg);
   assign tmp_match = running && (cnt == duty_temp_reg);

   // buffer to temporary: at once outside the band, deferred to its end inside it;
   // temporary to compare only at start and at the transfer event, never mid-compare
   always_comb begin
      next_buf     = duty_buffer_reg;
      next_temp    = duty_temp_reg;
      next_cmp     = duty_compare_reg;
      next_pending = pending;
      if (buf_wr) begin
         next_buf = buf_data;
      end
      if (buf_wr && (in_band && running)) begin
         next_pending = 1'b1; // see RULE8
      end else if (buf_wr) begin
         next_temp    = buf_data; // see RULE16
         next_pending = 1'b0;
      end else if (pending && !in_band) begin
         next_temp    = duty_buffer_reg; // see RULE8
         next_pending = 1'b0;
      end
      if (start) begin
         next_cmp = duty_temp_reg;
      end else if (xfer) begin
         next_cmp = duty_temp_reg; // see RULE16
      end
   end

   // phase outputs; no minimum width filter, so near the edges pulses just
   // get short, which the power stage must tolerate or software must avoid
   always_comb begin
      next_pos      = pos;
      next_neg      = neg;
      next_off_hold = off_hold;
      if (start) begin
         next_neg      = neg_lvl; // see RULE7
         next_pos      = 1'b0;
         next_off_hold = 1'b0;
      end else if (running) begin
         if (tmp_match) begin
            next_neg      = 1'b0; // see RULE2 RULE3 RULE13
            next_off_hold = 1'b1;
         end else if (cmp_match && !off_hold) begin
            next_neg = 1'b1; // see RULE1 RULE6 RULE10
         end else if (xfer) begin
            next_off_hold = 1'b0;
         end
         if (cmp_match && tmp_match) begin
            next_pos = pos; // see RULE14
         end else if (cmp_match) begin
            next_pos = 1'b0; // see RULE4 RULE11
         end else if (tmp_match) begin
            next_pos = 1'b1; // see RULE5 RULE12
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         duty_buffer_reg  <= cpw_pkg::RST_DUTY;
         duty_temp_reg    <= cpw_pkg::RST_DUTY;
         duty_compare_reg <= cpw_pkg::RST_DUTY;
         pending          <= 1'b0;
         off_hold         <= 1'b0;
         pos              <= 1'b0;
         neg              <= 1'b0;
      end else begin
         duty_buffer_reg  <= next_buf;
         duty_temp_reg    <= next_temp;
         duty_compare_reg <= next_cmp;
         pending          <= next_pending;
         off_hold         <= next_off_hold;
         pos              <= next_pos;
         neg              <= next_neg;
      end
   end

   assign temp_val = duty_temp_reg;
   assign cmp_val  = duty_compare_reg;
   assign buf_val  = duty_buffer_reg;
endmodule

// ==== cpw_gate_drv.sv ====
`timescale 1ns/10ps
// behavioural half-bridge gate driver on one complementary pair
module cpw_gate_drv (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        hi_gate,
   input  wire logic        lo_gate,
   output logic             node,
   output logic             overlap,
   output logic [15:0]      n_edges
);
   logic hi_q;
   logic lo_q;

   // node follows the gates; with both off it toggles every cycle, so no stale level
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hi_q    <= 1'b0;
         lo_q    <= 1'b0;
         node    <= 1'b0;
         overlap <= 1'b0;
         n_edges <= 16'h0000;
      end else begin
         hi_q <= hi_gate;
         lo_q <= lo_gate;
         if (hi_gate != hi_q || lo_gate != lo_q) begin
            n_edges <= n_edges + 16'h0001; // even minute pulses count
         end
         if (hi_gate && lo_gate) begin
            overlap <= 1'b1; // shoot-through would destroy the stage
         end
         node <= hi_gate ? 1'b1 : (lo_gate ? 1'b0 : ~node);
      end
   end
endmodule

// ==== cpw_top_assertions.sv ====
`timescale 1ns/10ps
module cpw_top_chk (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic [3:0]            reg_addr,
   input  wire logic [cpw_pkg::W-1:0] reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [cpw_pkg::W-1:0] reg_rdata,
   input  wire logic                  pos_phase_a,
   input  wire logic                  neg_phase_a,
   input  wire logic                  pos_phase_b,
   input  wire logic                  neg_phase_b
);
   logic [3:0] ctrl_q;
   logic [3:0] next_ctrl_q;

   // shadow of the control word; writes there are never refused
   always_comb begin
      next_ctrl_q = ctrl_q;
      if (reg_wr && reg_addr == cpw_pkg::OFS_CTRL) begin
         next_ctrl_q = reg_wdata[3:0];
      end
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= 4'h0;
      end else begin
         ctrl_q <= next_ctrl_q;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside read slot");
   chk_unmapped_read: assert property (reg_rd && reg_addr >= 4'hC |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_ctrl_readback: assert property (reg_rd && reg_addr == cpw_pkg::OFS_CTRL
      |=> reg_rdata == {12'h000, $past(ctrl_q)})
      else $error("control readback wrong");
   chk_excl_a: assert property (!(pos_phase_a && neg_phase_a))
      else $error("group a both phases on");
   chk_excl_b: assert property (!(pos_phase_b && neg_phase_b))
      else $error("group b both phases on");
   // counter is cleared and matches are gated off while stopped, so no match may move a phase
   chk_stop_hold: assert property (!ctrl_q[0] [*3]
      |=> $stable({pos_phase_a, neg_phase_a, pos_phase_b, neg_phase_b}))
      else $error("phase moved while stopped");
   chk_start_lvl_a: assert property ($rose(ctrl_q[0])
      |=> neg_phase_a == $past(ctrl_q[2]) && !pos_phase_a)
      else $error("group a start level wrong");
   chk_start_lvl_b: assert property ($rose(ctrl_q[0])
      |=> neg_phase_b == $past(ctrl_q[3]) && !pos_phase_b)
      else $error("group b start level wrong");

   cover property ($rose(neg_phase_b));
   cover property ($rose(pos_phase_b));
   cover property ($rose(ctrl_q[0]) && ctrl_q[1]);
endmodule

bind cpw_top cpw_top_chk u_chk (
   .sys_clk     (sys_clk),
   .rst         (rst),
   .reg_addr    (reg_addr),
   .reg_wdata   (reg_wdata),
   .reg_wr      (reg_wr),
   .reg_rd      (reg_rd),
   .reg_rdata   (reg_rdata),
   .pos_phase_a (pos_phase_a),
   .neg_phase_a (neg_phase_a),
   .pos_phase_b (pos_phase_b),
   .neg_phase_b (neg_phase_b)
);

// ==== cpw_top_tb.sv ====
`timescale 1ns/10ps
module cpw_top_tb;
   logic                  sys_clk, rst, reg_wr, reg_rd;
   logic [3:0]            reg_addr;
   logic [cpw_pkg::W-1:0] reg_wdata, reg_rdata;
   logic                  pa, na, pb, nb, node_a, node_b, ovl_a, ovl_b;
   logic [15:0]           edg_a, edg_b, e0;
   logic                  m;
   int                    n_fail, num_checks, cyc, t0;
   // reset-value table; the duty buffer is write-only and reads 0
   logic [3:0]  ra [10] = '{cpw_pkg::OFS_CTRL, cpw_pkg::OFS_DEAD, cpw_pkg::OFS_HALF,
      cpw_pkg::OFS_PERIOD, cpw_pkg::OFS_TEMP_A, cpw_pkg::OFS_COMPARE_A, cpw_pkg::OFS_TEMP_B,
      cpw_pkg::OFS_COMPARE_B, cpw_pkg::OFS_DUTY_A, 4'hC};
   logic [15:0] rv [10] = '{16'h0000, 16'h0010, 16'h0100, 16'h0110, 16'h0088, 16'h0088,
      16'h0088, 16'h0088, 16'h0000, 16'h0000};

   cpw_top DUT (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_phase_a(pa),
      .neg_phase_a(na), .pos_phase_b(pb), .neg_phase_b(nb));
   cpw_gate_drv u_drv_a (.sys_clk(sys_clk), .rst(rst), .hi_gate(pa), .lo_gate(na),
      .node(node_a), .overlap(ovl_a), .n_edges(edg_a));
   cpw_gate_drv u_drv_b (.sys_clk(sys_clk), .rst(rst), .hi_gate(pb), .lo_gate(nb),
      .node(node_b), .overlap(ovl_b), .n_edges(edg_b));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // cycle count for timed checks, plus a watchdog against hangs
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         n_fail++;
         test_done;
      end
   end

   task test_done;
      if (n_fail == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s exp %h got %h", nm, exp, got);
      end
   endtask

   task chk1(input string nm, input logic exp, input logic got);
      chk(nm, {15'h0000, exp}, {15'h0000, got});
   endtask

   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe
   task rd(input logic [3:0] a, input logic [15:0] exp, input string nm);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(nm, exp, reg_rdata);
   endtask

   // bounded by n: waits until n cycles after the mark
   task at(input int n);
      while (cyc - t0 < n) @(posedge sys_clk);
      #1;
   endtask

   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      n_fail = 0;
      num_checks = 0;
      cyc = 0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      wr(cpw_pkg::OFS_PERIOD, 16'hFFFF);
      for (int i = 0; i < 10; i++) begin
         rd(ra[i], rv[i], "reset value");
      end
      // duty b well clear of the minute-pulse regions; duty a near zero, inside the dead-time band
      for (int i = 0; i < 4; i++) begin
         m = i[1];
         wr(cpw_pkg::OFS_DUTY_A, 16'h0005);
         wr(cpw_pkg::OFS_DUTY_B, 16'h0040);
         rd(cpw_pkg::OFS_TEMP_B, 16'h0040, "temp b stopped");
         t0 = cyc;
         wr(cpw_pkg::OFS_CTRL, {12'h000, m, 1'b1, m, 1'b1});
         at(4);
         chk1("neg a start", 1'b1, na);
         chk1("neg b start", m, nb);
         chk1("pos a start", 1'b0, pa);
         at(i[0] ? 30 : 8);
         wr(cpw_pkg::OFS_DUTY_B, 16'h0060);
         at(32);
         chk1("pos a equal match", 1'b0, pa);
         chk1("neg a equal match", 1'b0, na);
         e0 = edg_a;
         at(80);
         chk1("neg b on", 1'b1, nb);
         chk1("pos b off", 1'b0, pb);
         rd(cpw_pkg::OFS_TEMP_B, 16'h0060, "temp b");
         rd(cpw_pkg::OFS_COMPARE_B, 16'h0040, "compare b");
         at(112);
         chk1("neg b off", 1'b0, nb);
         chk1("pos b on", 1'b1, pb);
         at(496);
         chk1("pos b falling", !m, pb);
         chk1("neg b held off", 1'b0, nb);
         rd(cpw_pkg::OFS_COMPARE_B, m ? 16'h0040 : 16'h0060, "compare b late");
         chk("edges a", e0, edg_a);
         wr(cpw_pkg::OFS_DEAD, 16'h0020);
         rd(cpw_pkg::OFS_DEAD, 16'h0010, "dead running");
         wr(cpw_pkg::OFS_CTRL, 16'h0000);
      end
      chk1("overlap a", 1'b0, ovl_a);
      chk1("overlap b", 1'b0, ovl_b);
      test_done;
   end
endmodule
